// >>> rtl/dmas_pkg.sv
// Function
// RL1: Two 16-bit pointers, bit 0 selects one.
// RL2: Pointer-control bit 2 ignores writes, reads zero.
// RL3: Pointer instructions use the selected pointer.
// RL4: Pointer low and high bytes separately accessible.
// RL5: Lower RAM reachable directly and indirectly.
// RL6: Upper RAM indirect only, separate from registers.
// RL7: Direct access above 7Fh hits special registers.
// RL8: Indirect access above 7Fh hits upper RAM.
// RL9: Select clear: external moves use 512-byte RAM.
// RL10: Expanded RAM access leaves port 0, strobes quiet.
// RL11: Pointer moves above 1FFh run bus cycles.
// RL12: Select set: index move drives 8-bit address.
// RL13: Pointer move: port 2 high, port 0 low.
// RL14: Bus moves pulse write or read strobe.
// RL15: Software keeps stack out of expanded RAM.
// RL16: Memory-control bit 1 picks move target.
// RL17: Memory-control bit 0 gates address latch strobe.
// RL18: Software writes no ones to unimplemented bits.
// RL19: Software saves select bit when switching pointers.
// RL20: Reset clears both memory-control bits.
package dmas_pkg;

   // Register locations in the special register space
   localparam logic [7:0] DMAS_AUX_MEM_ADDR = 8'h8E;
   localparam logic [7:0] DMAS_AUX_PTR_ADDR = 8'hA2;
   localparam logic [7:0] DMAS_PTR_LO_ADDR  = 8'h82;
   localparam logic [7:0] DMAS_PTR_HI_ADDR  = 8'h83;

   // Field positions
   localparam int DMAS_SEL_BIT     = 0;
   localparam int DMAS_FLAG_RO_BIT = 2;
   localparam int DMAS_EXT_SEL_BIT = 1;
   localparam int DMAS_GATE_BIT    = 0;
   localparam logic [7:0] DMAS_PTR_CTRL_WMASK = 8'hFB;

   // Reset values
   localparam logic [7:0] DMAS_PTR_CTRL_RST = 8'h00;
   localparam logic       DMAS_EXT_SEL_RST  = 1'b0;
   localparam logic       DMAS_GATE_RST     = 1'b0;

   // Address map limits
   localparam logic [7:0]  DMAS_LOWER_TOP  = 8'h7F;
   localparam logic [15:0] DMAS_EXPANDED_RAM_LIMIT = 16'h0200;
   localparam int          DMAS_EXPANDED_RAM_AW    = 9;
   localparam int          DMAS_DATA_W     = 8;

   // Timing counts in core clocks
   localparam logic [2:0] DMAS_ALE_DIV   = 3'h6;
   localparam logic [1:0] DMAS_STRB_CYC  = 2'h3;

   typedef enum logic [1:0] {
      DMAS_IDLE = 2'b00,
      DMAS_ADDR = 2'b01,
      DMAS_STRB = 2'b11,
      DMAS_DONE = 2'b10
   } dmas_state_t;

endpackage

// >>> rtl/dmas_expanded_ram.sv
`timescale 1ns/1ps
module dmas_expanded_ram #(
   parameter int AW = 9,
   parameter int DW = 8
) (
   // Clock
   input  wire logic          ref_clk,
   // Access
   input  wire logic          en,
   input  wire logic          we,
   input  wire logic [AW-1:0] addr,
   input  wire logic [DW-1:0] wdata,
   output      logic [DW-1:0] rdata
);

   logic [DW-1:0] mem_reg [0:(1<<AW)-1];

   // Contents are not reset; software must initialise what it reads
   always_ff @(posedge ref_clk) begin
      if (en) begin
         if (we) begin
            mem_reg[addr] <= wdata;
         end else begin
            rdata <= mem_reg[addr];
         end
      end
   end

endmodule

// >>> rtl/dmas_top.sv
`timescale 1ns/1ps
module dmas_top
   import dmas_pkg::*;
#(
   parameter logic [1:0] STRB_CYC = dmas_pkg::DMAS_STRB_CYC
) (
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        srst,
   // Special register access
   input  wire logic [7:0]  sfr_addr,
   input  wire logic        sfr_wr,
   input  wire logic        sfr_rd,
   input  wire logic [7:0]  sfr_wdata,
   output      logic [7:0]  sfr_rdata,
   output      logic        sfr_hit,
   // Internal data space decode
   input  wire logic        iram_req,
   input  wire logic        iram_indirect,
   input  wire logic [7:0]  iram_addr,
   output      logic        iram_lower_sel,
   output      logic        iram_upper_sel,
   output      logic        iram_sfr_sel,
   // Pointer instructions
   input  wire logic        ptr_inc,
   input  wire logic        ptr_load,
   input  wire logic [15:0] ptr_load_val,
   output      logic [15:0] data_pointer,
   // External moves
   input  wire logic        xmove_req,
   input  wire logic        xmove_write,
   input  wire logic        xmove_use_ptr,
   input  wire logic [7:0]  xmove_index,
   input  wire logic [7:0]  xmove_wdata,
   input  wire logic        code_move_ext,
   output      logic        xmove_ready,
   output      logic        xmove_done,
   output      logic [7:0]  xmove_rdata,
   // Port pins
   input  wire logic [7:0]  p2_latch,
   input  wire logic [7:0]  p0_in,
   output      logic [7:0]  p0_out,
   output      logic        p0_oe_n,
   output      logic [7:0]  p2_out,
   output      logic        wr_n,
   output      logic        rd_n,
   output      logic        ale
);
   import dmas_pkg::*;

   typedef struct packed {
      logic [15:0] ptr0;
      logic [15:0] ptr1;
      logic [7:0]  ptr_ctrl;
      logic        ext_sel;
      logic        gate;
      dmas_state_t st;
      logic [1:0]  cnt;
      logic [2:0]  div;
      logic [15:0] addr;
      logic [7:0]  wdata;
      logic        is_wr;
      logic        is_expanded_ram;
      logic [7:0]  rdata;
      logic        done;
      logic        ale;
      logic [7:0]  sfr_rdata;
      logic [7:0]  p0_out;
      logic        p0_oe_n;
      logic [7:0]  p2_out;
      logic        wr_n;
      logic        rd_n;
      logic [7:0]  p0_s1;
      logic [7:0]  p0_s2;
   } dmas_regs_t;

   localparam dmas_regs_t REGS_RST = '{
      ptr_ctrl: DMAS_PTR_CTRL_RST,
      ext_sel:  DMAS_EXT_SEL_RST,
      gate:     DMAS_GATE_RST,
      st:       DMAS_IDLE,
      p0_oe_n:  1'b1,
      wr_n:     1'b1,
      rd_n:     1'b1,
      default:  '0
   };

   dmas_regs_t        state_reg;
   dmas_regs_t        state_next;
   logic [15:0]       cur_ptr;
   logic [15:0]       upd_ptr;
   logic              internal_hit;
   logic              mem_en;
   logic [7:0]        mem_rdata;
   logic [DMAS_EXPANDED_RAM_AW-1:0] mem_addr;

   assign cur_ptr = state_reg.ptr_ctrl[DMAS_SEL_BIT] ? state_reg.ptr1 : state_reg.ptr0;  // RL1 RL3

   // Move target: expanded RAM unless selected off, or pointer past its top
   assign internal_hit = !state_reg.ext_sel &&
                         (!xmove_use_ptr || cur_ptr < DMAS_EXPANDED_RAM_LIMIT);  // RL9 RL16 RL11
   assign mem_en   = xmove_req && state_reg.st == DMAS_IDLE && internal_hit;
   assign mem_addr = xmove_use_ptr ? cur_ptr[DMAS_EXPANDED_RAM_AW-1:0] : {1'b0, xmove_index};

   dmas_expanded_ram #(
      .AW (DMAS_EXPANDED_RAM_AW),
      .DW (DMAS_DATA_W)
   ) u_expanded_ram (
      .ref_clk (ref_clk),
      .en      (mem_en),
      .we      (xmove_write),
      .addr    (mem_addr),
      .wdata   (xmove_wdata),
      .rdata   (mem_rdata)
   );

   always_comb begin
      state_next = state_reg;
      state_next.done = 1'b0;
      state_next.p0_s1 = p0_in;
      state_next.p0_s2 = state_reg.p0_s1;

      // Load wins over increment; a byte write in the same cycle overrides its byte
      upd_ptr = cur_ptr;
      if (ptr_load) begin
         upd_ptr = ptr_load_val;  // RL3
      end else if (ptr_inc) begin
         upd_ptr = cur_ptr + 16'h0001;  // RL3
      end
      if (sfr_wr && sfr_addr == DMAS_PTR_LO_ADDR) begin
         upd_ptr[7:0] = sfr_wdata;  // RL4
      end
      if (sfr_wr && sfr_addr == DMAS_PTR_HI_ADDR) begin
         upd_ptr[15:8] = sfr_wdata;  // RL4
      end
      if (state_reg.ptr_ctrl[DMAS_SEL_BIT]) begin
         state_next.ptr1 = upd_ptr;
      end else begin
         state_next.ptr0 = upd_ptr;
      end

      if (sfr_wr && sfr_addr == DMAS_AUX_MEM_ADDR) begin
         state_next.ext_sel = sfr_wdata[DMAS_EXT_SEL_BIT];  // RL16
         state_next.gate    = sfr_wdata[DMAS_GATE_BIT];  // RL17
      end
      if (sfr_wr && sfr_addr == DMAS_AUX_PTR_ADDR) begin
         state_next.ptr_ctrl = sfr_wdata & DMAS_PTR_CTRL_WMASK;  // RL1 RL2
      end

      if (sfr_rd) begin
         case (sfr_addr)
            DMAS_PTR_LO_ADDR:  state_next.sfr_rdata = cur_ptr[7:0];  // RL4
            DMAS_PTR_HI_ADDR:  state_next.sfr_rdata = cur_ptr[15:8];  // RL4
            DMAS_AUX_MEM_ADDR: state_next.sfr_rdata = {6'h00, state_reg.ext_sel, state_reg.gate};
            DMAS_AUX_PTR_ADDR: state_next.sfr_rdata = state_reg.ptr_ctrl & DMAS_PTR_CTRL_WMASK;  // RL2
            default:           state_next.sfr_rdata = 8'h00;
         endcase
      end

      state_next.div = (state_reg.div == DMAS_ALE_DIV - 3'h1) ? 3'h0 : state_reg.div + 3'h1;

      case (state_reg.st)
         DMAS_IDLE: begin
            state_next.p2_out = p2_latch;
            if (xmove_req) begin
               state_next.is_wr = xmove_write;
               state_next.wdata = xmove_wdata;
               state_next.addr  = xmove_use_ptr ? cur_ptr : {8'h00, xmove_index};  // RL12 RL13
               if (xmove_use_ptr) begin
                  state_next.p2_out = cur_ptr[15:8];  // RL10 RL13
               end
               if (internal_hit) begin
                  // Port 0 and strobes stay idle for the on-chip RAM
                  state_next.is_expanded_ram = 1'b1;  // RL10
                  state_next.st = DMAS_DONE;
               end else begin
                  state_next.is_expanded_ram = 1'b0;
                  state_next.p0_out  = xmove_use_ptr ? cur_ptr[7:0] : xmove_index;  // RL12 RL13
                  state_next.p0_oe_n = 1'b0;
                  state_next.st = DMAS_ADDR;
               end
            end
         end
         DMAS_ADDR: begin
            state_next.st  = DMAS_STRB;
            state_next.cnt = STRB_CYC - 2'h1;
            if (state_reg.is_wr) begin
               state_next.p0_out = state_reg.wdata;
               state_next.wr_n   = 1'b0;  // RL14
            end else begin
               state_next.p0_oe_n = 1'b1;
               state_next.rd_n    = 1'b0;  // RL14
            end
         end
         DMAS_STRB: begin
            if (state_reg.cnt == 2'h0) begin
               state_next.st   = DMAS_DONE;
               state_next.wr_n = 1'b1;
               state_next.rd_n = 1'b1;
               if (!state_reg.is_wr) begin
                  state_next.rdata = state_reg.p0_s2;
               end
            end else begin
               state_next.cnt = state_reg.cnt - 2'h1;
            end
         end
         DMAS_DONE: begin
            state_next.st      = DMAS_IDLE;
            state_next.done    = 1'b1;
            state_next.p0_oe_n = 1'b1;
            if (state_reg.is_expanded_ram && !state_reg.is_wr) begin
               state_next.rdata = mem_rdata;  // RL9
            end
         end
         default: begin
            state_next.st = DMAS_IDLE;
         end
      endcase

      // Gated mode trades the free-running strobe for lower emissions
      if (state_reg.gate) begin
         state_next.ale = state_next.st == DMAS_ADDR || code_move_ext;  // RL17
      end else begin
         state_next.ale = state_next.div == 3'h0 || state_next.st == DMAS_ADDR;  // RL17
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         state_reg <= REGS_RST;  // RL20
      end else begin
         state_reg <= state_next;
      end
   end

   // Address-mode decode of the 256-byte internal space
   always_comb begin
      iram_lower_sel = iram_req && iram_addr <= DMAS_LOWER_TOP;  // RL5
      iram_upper_sel = iram_req && iram_addr > DMAS_LOWER_TOP && iram_indirect;  // RL6 RL8
      iram_sfr_sel   = iram_req && iram_addr > DMAS_LOWER_TOP && !iram_indirect;  // RL7
   end

   assign sfr_hit      = sfr_addr == DMAS_AUX_MEM_ADDR || sfr_addr == DMAS_AUX_PTR_ADDR ||
                         sfr_addr == DMAS_PTR_LO_ADDR || sfr_addr == DMAS_PTR_HI_ADDR;
   assign sfr_rdata    = state_reg.sfr_rdata;
   assign data_pointer = cur_ptr;
   assign xmove_ready  = state_reg.st == DMAS_IDLE;
   assign xmove_done   = state_reg.done;
   assign xmove_rdata  = state_reg.rdata;
   assign p0_out       = state_reg.p0_out;
   assign p0_oe_n      = state_reg.p0_oe_n;
   assign p2_out       = state_reg.p2_out;
   assign wr_n         = state_reg.wr_n;
   assign rd_n         = state_reg.rd_n;
   assign ale          = state_reg.ale;

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (srst);

   a_sel_follows_write: assert property (  // RL1
      sfr_wr && sfr_addr == DMAS_AUX_PTR_ADDR |=> state_reg.ptr_ctrl[DMAS_SEL_BIT] == $past(sfr_wdata[DMAS_SEL_BIT])
   ) else $error("pointer select did not follow write");

   a_flag_reads_zero: assert property (  // RL2
      sfr_rd && sfr_addr == DMAS_AUX_PTR_ADDR |=> sfr_rdata[DMAS_FLAG_RO_BIT] == 1'b0
   ) else $error("read-only flag bit read as one");

   a_ptr_increment: assert property (  // RL3
      ptr_inc && !ptr_load && !sfr_wr |=> data_pointer == $past(data_pointer) + 16'h0001
   ) else $error("selected pointer did not increment");

   a_lower_both_modes: assert property (  // RL5
      iram_req && iram_addr <= DMAS_LOWER_TOP |-> iram_lower_sel && !iram_upper_sel && !iram_sfr_sel
   ) else $error("lower RAM not selected");

   a_direct_to_sfr: assert property (  // RL7
      iram_req && !iram_indirect && iram_addr[7] |-> iram_sfr_sel && !iram_upper_sel
   ) else $error("direct access missed special registers");

   a_indirect_upper: assert property (  // RL8
      iram_req && iram_indirect && iram_addr[7] |-> iram_upper_sel && !iram_sfr_sel
   ) else $error("indirect access missed upper RAM");

   a_expanded_ram_pins_quiet: assert property (  // RL10
      mem_en |=> (wr_n && rd_n && p0_oe_n) ##1 (xmove_done && wr_n && rd_n && p0_oe_n)
   ) else $error("expanded RAM access disturbed bus pins");

   a_read_strobe: assert property (  // RL14
      xmove_ready && xmove_req && !internal_hit && !xmove_write |-> ##2 (!rd_n && wr_n) [*3] ##1 rd_n
   ) else $error("read strobe timing wrong");

   a_ptr_high_port: assert property (  // RL13
      xmove_ready && xmove_req && xmove_use_ptr |=> p2_out == $past(cur_ptr[15:8])
   ) else $error("port 2 lacks pointer high byte");

   a_index_low_addr: assert property (  // RL12
      xmove_ready && xmove_req && !internal_hit && !xmove_use_ptr |=> p0_out == $past(xmove_index) && !p0_oe_n
   ) else $error("index address missing on port 0");

   a_ale_gated: assert property (  // RL17
      state_reg.gate && xmove_ready && !xmove_req && !code_move_ext |=> !ale
   ) else $error("gated address strobe pulsed");

   a_reset_ctrl: assert property (  // RL20
      $fell(srst) |-> !state_reg.ext_sel && !state_reg.gate
   ) else $error("control bits not cleared by reset");

   c_ext_read: cover property (xmove_ready && xmove_req && !internal_hit && !xmove_write ##6 xmove_done);
   c_expanded_ram_write: cover property (mem_en && xmove_write);
   c_ptr_swap: cover property (sfr_wr && sfr_addr == DMAS_AUX_PTR_ADDR ##1 ptr_inc);
   c_gated_ale: cover property (state_reg.gate && ale);

endmodule

// >>> verif/dmas_ext_mem.sv
`timescale 1ns/1ps
module dmas_ext_mem (
   // Bus pins seen from the memory
   input  wire logic       ref_clk,
   input  wire logic [7:0] p0_out,
   input  wire logic       p0_oe_n,
   input  wire logic [7:0] p2_out,
   input  wire logic       ale,
   input  wire logic       wr_n,
   input  wire logic       rd_n,
   // Data back to the core
   output      logic [7:0] p0_in
);
   logic [7:0]  mem [0:65535];
   logic [15:0] addr;
   logic        oe_q;
   initial begin
      addr = 16'h0000;
      oe_q = 1'b1;
      for (int k = 0; k < 65536; k++) begin
         mem[k] = 8'h00;
      end
   end
   always @(posedge ref_clk) begin
      oe_q <= p0_oe_n;
      // Only the strobe that opens a cycle latches; a free-running one may recur over data
      if (ale && !p0_oe_n && oe_q) begin
         addr <= {p2_out, p0_out};
      end
      if (!wr_n) begin
         mem[addr] <= p0_out;
      end
   end
   // Asynchronous memory answers as soon as the read strobe falls;
   // a released bus shows the inverse so stale data can never pass
   assign p0_in = rd_n ? ~mem[addr] : mem[addr];
endmodule

// >>> verif/dmas_top_tb.sv
`timescale 1ns/1ps
module dmas_top_tb;
   import dmas_pkg::*;
   logic ref_clk, srst, sfr_wr, sfr_rd, sfr_hit, iram_req, iram_indirect, lo_sel, up_sel, sf_sel;
   logic ptr_inc, ptr_load, xmove_req, xmove_write, xmove_use_ptr, code_move_ext, xmove_ready, xmove_done;
   logic p0_oe_n, wr_n, rd_n, ale, bus_seen, oe_q;
   logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, iram_addr, xmove_index, xmove_wdata, xmove_rdata;
   logic [7:0]  p2_latch, p0_in, p0_out, p2_out, lat_lo, lat_hi;
   logic [15:0] ptr_load_val, data_pointer;
   int n_errors = 0;
   int total_checks = 0;
   int n_ale;
   int i;

   dmas_top dut_u (.ref_clk(ref_clk), .srst(srst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
      .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit), .iram_req(iram_req),
      .iram_indirect(iram_indirect), .iram_addr(iram_addr), .iram_lower_sel(lo_sel), .iram_upper_sel(up_sel),
      .iram_sfr_sel(sf_sel), .ptr_inc(ptr_inc), .ptr_load(ptr_load), .ptr_load_val(ptr_load_val),
      .data_pointer(data_pointer), .xmove_req(xmove_req), .xmove_write(xmove_write),
      .xmove_use_ptr(xmove_use_ptr), .xmove_index(xmove_index), .xmove_wdata(xmove_wdata),
      .code_move_ext(code_move_ext), .xmove_ready(xmove_ready), .xmove_done(xmove_done),
      .xmove_rdata(xmove_rdata), .p2_latch(p2_latch), .p0_in(p0_in), .p0_out(p0_out), .p0_oe_n(p0_oe_n),
      .p2_out(p2_out), .wr_n(wr_n), .rd_n(rd_n), .ale(ale));

   dmas_ext_mem mem_u (.ref_clk(ref_clk), .p0_out(p0_out), .p0_oe_n(p0_oe_n), .p2_out(p2_out), .ale(ale),
      .wr_n(wr_n), .rd_n(rd_n), .p0_in(p0_in));

   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end

   // Bus activity seen by the bench, independent of the memory model
   always @(posedge ref_clk) begin
      oe_q <= p0_oe_n;
      // Only the strobe that opens a bus cycle carries the address
      if (ale && !p0_oe_n && oe_q) begin
         lat_lo <= p0_out;
         lat_hi <= p2_out;
      end
      if (!wr_n || !rd_n) begin
         bus_seen <= 1'b1;
      end
      if (ale) begin
         n_ale <= n_ale + 1;
      end
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
      sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = 1'b1;
      @(negedge ref_clk);
      sfr_wr = 1'b0;
      // Spare cycle so a following call never re-raises the strobe in the same step
      @(negedge ref_clk);
   endtask

   task automatic sfr_read(input logic [7:0] a, input logic [7:0] exp);
      sfr_addr = a;
      sfr_rd = 1'b1;
      @(negedge ref_clk);
      sfr_rd = 1'b0;
      chk({8'h00, sfr_rdata}, {8'h00, exp}, "register read");
      @(negedge ref_clk);
   endtask

   task automatic ptr_op(input logic ld, input logic [15:0] v);
      ptr_load = ld;
      ptr_inc = !ld;
      ptr_load_val = v;
      @(negedge ref_clk);
      ptr_load = 1'b0;
      ptr_inc = 1'b0;
   endtask

   // One external move; checks completion latency and, for reads, the data
   task automatic xmove(input logic wr, input logic up, input logic [7:0] ix, input logic [7:0] d, input int lat);
      xmove_write = wr;
      xmove_use_ptr = up;
      xmove_index = ix;
      xmove_wdata = d;
      bus_seen = 1'b0;
      xmove_req = 1'b1;
      @(negedge ref_clk);
      xmove_req = 1'b0;
      for (i = 0; i < 20 && xmove_done !== 1'b1; i++) @(negedge ref_clk);
      chk(16'(i + 1), lat[15:0], "move latency");
      if (!wr) chk({8'h00, xmove_rdata}, {8'h00, d}, "move read data");
      @(negedge ref_clk);
   endtask

   task automatic complete_run;
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   initial begin
      #2000000;
      n_errors++;
      complete_run();
   end

   initial begin
      {sfr_wr, sfr_rd, iram_req, iram_indirect, ptr_inc, ptr_load, xmove_req, xmove_write} = 8'h00;
      {xmove_use_ptr, code_move_ext, bus_seen, oe_q} = 4'h1;
      {sfr_addr, sfr_wdata, iram_addr, xmove_index, xmove_wdata} = 40'h0;
      {lat_lo, lat_hi, ptr_load_val, n_ale} = 0;
      p2_latch = 8'hE1;
      srst = 1'b1;
      repeat (16) @(negedge ref_clk);
      srst = 1'b0;
      chk({15'h0, xmove_ready}, 16'h1, "ready after reset");
      sfr_read(DMAS_AUX_MEM_ADDR, 8'h00);
      sfr_read(DMAS_AUX_PTR_ADDR, 8'h00);
      sfr_read(8'h90, 8'h00);
      chk({15'h0, sfr_hit}, 16'h0, "unmapped hit");
      ptr_op(1'b1, 16'h1234);
      sfr_write(DMAS_AUX_PTR_ADDR, 8'hFF);
      sfr_read(DMAS_AUX_PTR_ADDR, 8'hFB);
      sfr_write(DMAS_PTR_LO_ADDR, 8'hCD);
      sfr_write(DMAS_PTR_HI_ADDR, 8'hAB);
      chk(data_pointer, 16'hABCD, "second pointer");
      ptr_op(1'b0, 16'h0000);
      chk(data_pointer, 16'hABCE, "increment");
      sfr_write(DMAS_AUX_PTR_ADDR, 8'hFC);
      sfr_read(DMAS_AUX_PTR_ADDR, 8'hF8);
      chk(data_pointer, 16'h1234, "first pointer kept");
      sfr_read(DMAS_PTR_LO_ADDR, 8'h34);
      chk({15'h0, sfr_hit}, 16'h1, "pointer byte hit");
      iram_req = 1'b1;
      for (int k = 0; k < 8; k++) begin
         iram_addr = (k < 4) ? 8'h7F + 8'(k) : 8'(k * 60);
         iram_indirect = k[0];
         #1;
         chk({13'h0, lo_sel, up_sel, sf_sel}, (iram_addr <= 8'h7F) ? 16'h4 : iram_indirect ? 16'h2 : 16'h1,
            "decode");
      end
      iram_req = 1'b0;
      xmove(1'b1, 1'b0, 8'hA0, 8'h5A, 2);
      xmove(1'b0, 1'b0, 8'hA0, 8'h5A, 2);
      ptr_op(1'b1, 16'h01FF);
      xmove(1'b1, 1'b1, 8'h00, 8'h77, 2);
      xmove(1'b0, 1'b1, 8'h00, 8'h77, 2);
      chk({15'h0, bus_seen}, 16'h0, "strobes quiet on expanded ram");
      ptr_op(1'b0, 16'h0000);
      xmove(1'b1, 1'b1, 8'h00, 8'h3C, 6);
      chk({lat_hi, lat_lo}, 16'h0200, "bus address");
      xmove(1'b0, 1'b1, 8'h00, 8'h3C, 6);
      chk({15'h0, bus_seen}, 16'h1, "read strobe");
      sfr_write(DMAS_AUX_MEM_ADDR, 8'h03);
      sfr_read(DMAS_AUX_MEM_ADDR, 8'h03);
      xmove(1'b1, 1'b0, 8'h55, 8'h99, 6);
      chk({lat_hi, lat_lo}, 16'hE155, "index address");
      xmove(1'b0, 1'b0, 8'h55, 8'h99, 6);
      ptr_op(1'b1, 16'h0010);
      xmove(1'b0, 1'b1, 8'h00, 8'h00, 6);
      n_ale = 0;
      repeat (60) @(negedge ref_clk);
      chk(n_ale[15:0], 16'h0, "gated latch strobe");
      code_move_ext = 1'b1;
      repeat (12) @(negedge ref_clk);
      code_move_ext = 1'b0;
      chk({15'h0, n_ale > 0}, 16'h1, "code move strobe");
      sfr_write(DMAS_AUX_MEM_ADDR, 8'h00);
      n_ale = 0;
      repeat (60) @(negedge ref_clk);
      chk(n_ale[15:0], 16'd10, "free-running latch strobe");
      complete_run();
   end
endmodule
